//--- rtcial_pkg.sv
package rtcial_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] adr_offset = 8'hac;
  localparam logic [7:0] dat_offset = 8'had;
  localparam logic [7:0] key_offset = 8'hae;

  // ************************************************************
  // key codes and lock state values
  // ************************************************************
  localparam logic [7:0] key_first = 8'ha5;
  localparam logic [7:0] key_second = 8'hf1;
  localparam logic [7:0] state_locked = 8'h00;
  localparam logic [7:0] state_half = 8'h01;
  localparam logic [7:0] state_open = 8'h02;
  localparam logic [7:0] state_dead = 8'h03;

  // ************************************************************
  // address register fields
  // ************************************************************
  localparam int busy_bit = 7;
  localparam int auto_read_enable_bit = 6;
  localparam int unused_bit = 5;
  localparam int short_bit = 4;
  localparam int addr_msb = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic auto_read_enable_reset = 1'b0;
  localparam logic short_reset = 1'b1;
  localparam logic [3:0] addr_reset = 4'h0;
  localparam logic [7:0] data_reset = 8'h00;

  // ************************************************************
  // access timing in system clocks
  // ************************************************************
  localparam logic [2:0] long_cycles = 3'h7;
  localparam logic [2:0] short_cycles = 3'h6;

  // ************************************************************
  // auto-increment windows
  // ************************************************************
  localparam logic [3:0] snap_first = 4'h0;
  localparam logic [3:0] snap_last = 4'h3;
  localparam logic [3:0] match_first = 4'h8;
  localparam logic [3:0] match_last = 4'hb;

  typedef enum logic [1:0] {lk_idle, lk_half, lk_open, lk_dead} rtcial_lock_e;
endpackage

//--- rtcial_lock.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] key register read returns 0x00 locked, 0x01 half keyed, 0x02 unlocked.
// [R2] disabled state reads 0x03 and holds until system reset.
// [R3] writing 0xa5 then 0xf1 from locked unlocks the interface.
// [R4] awaiting second code, any value but 0xf1 disables the interface.
// [R5] any key write while unlocked re-locks the interface.
// [R6] key writes while disabled change nothing.
// [R7] address bit 7 shows busy; writing 1 starts an indirect read.
// [R8] address bit 6 enables autoread.
// [R9] address bit 4 enables the short access strobe.
// [R10] address bit 5 reads zero, writes to it ignored.
// [R11] address bits 3:0 pick the internal register targeted.
// [R12] address field increments after accesses to snapshot or match bytes.
// [R13] reset clears the lock state to locked.
// [R14] wrong or out-of-order codes, or locked access, disable until reset.
// [R15] writing the data register starts an indirect write.
// [R16] access takes 7 clocks, 6 with short strobe; short on at reset.
// [R17] with autoread, each data register read while unlocked and not busy starts the next read.
// [R18] busy stays high from start to completion, then hardware clears it.
module rtcial_lock (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic [3:0] rtc_addr,
  output logic [7:0] rtc_wdata,
  input wire logic [7:0] rtc_rdata,
  output logic rtc_rd_strobe,
  output logic rtc_wr_strobe
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    rtcial_pkg::rtcial_lock_e lk;
    logic busy;
    logic auto_read_enable;
    logic short_en;
    logic [3:0] addr;
    logic [7:0] data;
    logic [2:0] cnt;
    logic run_short;
    logic is_write;
    logic [7:0] rdata;
    logic rd_stb;
    logic wr_stb;
  } rtcial_state_s;

  rtcial_state_s q;
  rtcial_state_s next_q;

  function automatic logic [7:0] rtcial_code(
    input rtcial_pkg::rtcial_lock_e s
  );
    unique case (s)
      rtcial_pkg::lk_idle: rtcial_code = rtcial_pkg::state_locked;
      rtcial_pkg::lk_half: rtcial_code = rtcial_pkg::state_half;
      rtcial_pkg::lk_open: rtcial_code = rtcial_pkg::state_open;
      rtcial_pkg::lk_dead: rtcial_code = rtcial_pkg::state_dead;
    endcase
  endfunction

  function automatic logic rtcial_incr(input logic [3:0] a);
    rtcial_incr = (a <= rtcial_pkg::snap_last) ||
      (a >= rtcial_pkg::match_first && a <= rtcial_pkg::match_last);
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  logic key_wr;
  logic adr_wr;
  logic dat_wr;
  logic dat_rd;
  logic adr_rd;
  logic ind_touch;
  logic done;

  assign key_wr = sfr_wr && sfr_addr == rtcial_pkg::key_offset;
  assign adr_wr = sfr_wr && sfr_addr == rtcial_pkg::adr_offset;
  assign dat_wr = sfr_wr && sfr_addr == rtcial_pkg::dat_offset;
  assign dat_rd = sfr_rd && sfr_addr == rtcial_pkg::dat_offset;
  assign adr_rd = sfr_rd && sfr_addr == rtcial_pkg::adr_offset;
  assign ind_touch = adr_wr || dat_wr || adr_rd || dat_rd;
  assign done = q.busy && q.cnt == 3'h0;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic start_rd;
    logic start_wr;
    logic ok;
    next_q = q;
    start_rd = 1'b0;
    start_wr = 1'b0;
    ok = q.lk == rtcial_pkg::lk_open;

    // lock and key
    unique case (q.lk)
      rtcial_pkg::lk_idle: begin
        if (key_wr) begin
          if (sfr_wdata == rtcial_pkg::key_first) begin
            next_q.lk = rtcial_pkg::lk_half; // [R3]
          end else begin
            next_q.lk = rtcial_pkg::lk_dead; // [R14]
          end
        end else if (ind_touch) begin
          next_q.lk = rtcial_pkg::lk_dead; // [R14]
        end
      end
      rtcial_pkg::lk_half: begin
        if (key_wr) begin
          if (sfr_wdata == rtcial_pkg::key_second) begin
            next_q.lk = rtcial_pkg::lk_open; // [R3]
          end else begin
            next_q.lk = rtcial_pkg::lk_dead; // [R4]
          end
        end else if (ind_touch) begin
          next_q.lk = rtcial_pkg::lk_dead; // [R14]
        end
      end
      rtcial_pkg::lk_open: begin
        if (key_wr) begin
          next_q.lk = rtcial_pkg::lk_idle; // [R5]
        end
      end
      rtcial_pkg::lk_dead: begin
        next_q.lk = rtcial_pkg::lk_dead; // [R2] [R6]
      end
    endcase

    // completion of a running transfer
    if (q.busy) begin
      if (done) begin
        next_q.busy = 1'b0; // [R18]
        if (!q.is_write) begin
          next_q.data = rtc_rdata;
        end
        if (rtcial_incr(q.addr)) begin
          next_q.addr = q.addr + 4'h1; // [R12]
        end
      end else begin
        next_q.cnt = q.cnt - 3'h1;
      end
    end

    // register writes are refused while a transfer is running
    if (ok && !q.busy) begin
      if (adr_wr) begin
        next_q.auto_read_enable = sfr_wdata[rtcial_pkg::auto_read_enable_bit]; // [R8]
        next_q.short_en = sfr_wdata[rtcial_pkg::short_bit]; // [R9]
        next_q.addr = sfr_wdata[rtcial_pkg::addr_msb:0]; // [R11]
        start_rd = sfr_wdata[rtcial_pkg::busy_bit]; // [R7]
      end else if (dat_wr) begin
        next_q.data = sfr_wdata;
        start_wr = 1'b1; // [R15]
      end else if (dat_rd && q.auto_read_enable) begin
        start_rd = 1'b1; // [R17]
      end
    end

    if (start_rd || start_wr) begin
      next_q.busy = 1'b1; // [R18]
      next_q.is_write = start_wr;
      next_q.run_short = adr_wr ? sfr_wdata[rtcial_pkg::short_bit]
                                : q.short_en;
      // count loaded one short so busy spans exactly the access length
      if (next_q.run_short) begin
        next_q.cnt = rtcial_pkg::short_cycles - 3'h1; // [R16]
      end else begin
        next_q.cnt = rtcial_pkg::long_cycles - 3'h1; // [R16]
      end
    end

    // read data, registered so every output is a flop
    next_q.rdata = 8'h00;
    if (sfr_rd) begin
      if (sfr_addr == rtcial_pkg::key_offset) begin
        next_q.rdata = rtcial_code(q.lk); // [R1] [R2]
      end else if (adr_rd && ok) begin
        next_q.rdata = {q.busy, q.auto_read_enable, 1'b0, q.short_en, q.addr}; // [R10]
      end else if (dat_rd && ok) begin
        next_q.rdata = q.data;
      end
    end

    if (reset) begin
      next_q.lk = rtcial_pkg::lk_idle; // [R13]
      next_q.busy = 1'b0;
      next_q.auto_read_enable = rtcial_pkg::auto_read_enable_reset;
      next_q.short_en = rtcial_pkg::short_reset; // [R16]
      next_q.addr = rtcial_pkg::addr_reset;
      next_q.data = rtcial_pkg::data_reset;
      next_q.cnt = 3'h0;
      next_q.run_short = 1'b0;
      next_q.is_write = 1'b0;
      next_q.rdata = 8'h00;
    end

    // strobes get flops of their own so no output passes through gating
    next_q.rd_stb = next_q.busy && !next_q.is_write; // [R7]
    next_q.wr_stb = next_q.busy && next_q.is_write; // [R15]
  end

  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the strobes are levels spanning the whole access; internal data
  // is sampled on the last busy cycle
  assign sfr_rdata = q.rdata;
  assign rtc_addr = q.addr;
  assign rtc_wdata = q.data;
  assign rtc_rd_strobe = q.rd_stb;
  assign rtc_wr_strobe = q.wr_stb;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  key_read_code_a: assert property ( // [R1]
    sfr_rd && sfr_addr == rtcial_pkg::key_offset |=>
    sfr_rdata == rtcial_code($past(q.lk)))
    else $error("key read code wrong");
  dead_sticky_a: assert property ( // [R2]
    q.lk == rtcial_pkg::lk_dead |=> q.lk == rtcial_pkg::lk_dead)
    else $error("disabled state left");
  first_key_a: assert property ( // [R3]
    q.lk == rtcial_pkg::lk_idle && key_wr &&
    sfr_wdata == rtcial_pkg::key_first |=> q.lk == rtcial_pkg::lk_half)
    else $error("first key not taken");
  unlock_pair_a: assert property ( // [R3]
    q.lk == rtcial_pkg::lk_half && key_wr &&
    sfr_wdata == rtcial_pkg::key_second |=> q.lk == rtcial_pkg::lk_open)
    else $error("second key did not unlock");
  bad_second_a: assert property ( // [R4]
    q.lk == rtcial_pkg::lk_half && key_wr &&
    sfr_wdata != rtcial_pkg::key_second |=> q.lk == rtcial_pkg::lk_dead)
    else $error("wrong second key not disabled");
  relock_a: assert property ( // [R5]
    q.lk == rtcial_pkg::lk_open && key_wr |=> q.lk == rtcial_pkg::lk_idle)
    else $error("key write did not relock");
  locked_access_a: assert property ( // [R14]
    q.lk == rtcial_pkg::lk_idle && !key_wr && ind_touch |=>
    q.lk == rtcial_pkg::lk_dead && !q.busy)
    else $error("locked access not disabled");
  bit5_zero_a: assert property ( // [R10]
    adr_rd |=> sfr_rdata[rtcial_pkg::unused_bit] == 1'b0)
    else $error("unused bit read nonzero");
  read_start_a: assert property ( // [R7]
    q.lk == rtcial_pkg::lk_open && !q.busy && adr_wr &&
    sfr_wdata[rtcial_pkg::busy_bit] |=> rtc_rd_strobe &&
    rtc_addr == $past(sfr_wdata[rtcial_pkg::addr_msb:0]))
    else $error("busy write did not start a read");
  read_load_a: assert property ( // [R7]
    done && !q.is_write |=> q.data == $past(rtc_rdata))
    else $error("read data not loaded");
  auto_start_a: assert property ( // [R17]
    q.lk == rtcial_pkg::lk_open && !q.busy && dat_rd && q.auto_read_enable |=>
    rtc_rd_strobe)
    else $error("autoread did not start");
  no_auto_a: assert property ( // [R8]
    q.lk == rtcial_pkg::lk_open && !q.busy && dat_rd && !q.auto_read_enable |=>
    !q.busy)
    else $error("read started without autoread");
  write_start_a: assert property ( // [R15]
    q.lk == rtcial_pkg::lk_open && !q.busy && dat_wr |=>
    rtc_wr_strobe && rtc_wdata == $past(sfr_wdata))
    else $error("data write did not start");
  long_len_a: assert property ( // [R16]
    $rose(q.busy) && !q.run_short |-> q.busy [*7] ##1 !q.busy)
    else $error("long access length wrong");
  short_len_a: assert property ( // [R16] [R18]
    $rose(q.busy) && q.run_short |-> q.busy [*6] ##1 !q.busy)
    else $error("short access length wrong");
  busy_end_a: assert property ( // [R18]
    done |=> !q.busy && !rtc_rd_strobe && !rtc_wr_strobe)
    else $error("busy not cleared at completion");
  strobe_busy_a: assert property ( // [R18]
    q.busy == (rtc_rd_strobe || rtc_wr_strobe))
    else $error("strobe does not follow busy");
  target_hold_a: assert property ( // [R11]
    q.busy && !done |=> $stable(rtc_addr) && $stable(rtc_wdata))
    else $error("target moved during access");
  incr_a: assert property ( // [R12]
    done && rtcial_incr(q.addr) |=>
    rtc_addr == 4'($past(q.addr) + 4'h1))
    else $error("address did not increment");
  no_incr_a: assert property ( // [R12]
    done && !rtcial_incr(q.addr) |=> $stable(rtc_addr))
    else $error("address moved outside the windows");
  reset_lock_a: assert property ( // [R13]
    @(posedge mclk) $past(reset) |->
    q.lk == rtcial_pkg::lk_idle && q.short_en)
    else $error("reset state wrong");

  unlock_c: cover property (q.lk == rtcial_pkg::lk_half ##1
    q.lk == rtcial_pkg::lk_open);
  long_read_c: cover property ($rose(rtc_rd_strobe) && !q.run_short);
  autoread_c: cover property (dat_rd && q.auto_read_enable && !q.busy ##1 q.busy);
  write_c: cover property ($rose(rtc_wr_strobe));
  dead_c: cover property (q.lk == rtcial_pkg::lk_dead);

endmodule
`default_nettype wire

//--- rtcial_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module rtcial_regfile (
  input wire logic mclk,
  input wire logic [3:0] rtc_addr,
  input wire logic [7:0] rtc_wdata,
  input wire logic rtc_rd_strobe,
  input wire logic rtc_wr_strobe,
  output logic [7:0] rtc_rdata
);
  logic [7:0] mem [16];
  logic [7:0] junk = 8'h00;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'h40 + 8'(i);
    end
  end
  // idle bus shows a pattern that moves every cycle, so stale data never
  // happens to match
  always @(posedge mclk) begin
    junk <= ~junk ^ 8'h3c;
    if (rtc_wr_strobe) begin
      mem[rtc_addr] <= rtc_wdata;
    end
  end
  assign rtc_rdata = rtc_rd_strobe ? mem[rtc_addr] : junk;
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ka = rtcial_pkg::key_offset;
  localparam logic [7:0] aa = rtcial_pkg::adr_offset;
  localparam logic [7:0] da = rtcial_pkg::dat_offset;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] rtc_wdata;
  logic [7:0] rtc_rdata;
  logic [3:0] rtc_addr;
  logic rtc_rd_strobe;
  logic rtc_wr_strobe;
  int error_cnt = 0;
  int check_count = 0;
  rtcial_lock u_rtcial_lock (.mclk(mclk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rtc_addr(rtc_addr),
    .rtc_wdata(rtc_wdata), .rtc_rdata(rtc_rdata),
    .rtc_rd_strobe(rtc_rd_strobe), .rtc_wr_strobe(rtc_wr_strobe));
  rtcial_regfile u_rtcial_regfile (.mclk(mclk), .rtc_addr(rtc_addr),
    .rtc_wdata(rtc_wdata), .rtc_rd_strobe(rtc_rd_strobe),
    .rtc_wr_strobe(rtc_wr_strobe), .rtc_rdata(rtc_rdata));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD t=%0t strobe length %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk8(sfr_rdata, exp);
  endtask
  // counts the remaining strobe cycles; bounded so a stuck strobe ends
  task automatic run_len(input logic wr_side, input int exp);
    int n;
    n = 0;
    while ((wr_side ? rtc_wr_strobe : rtc_rd_strobe) === 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chkn(n, exp);
  endtask
  task automatic do_reset;
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'b0;
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    do_reset;
    wr(ka, rtcial_pkg::key_first);
    wr(ka, 8'h00);
    rdchk(ka, 8'h03);
    do_reset;
    rdchk(ka, 8'h00);
    endt("bad second code");
    wr(ka, rtcial_pkg::key_first);
    rdchk(ka, 8'h01);
    wr(ka, rtcial_pkg::key_second);
    rdchk(ka, 8'h02);
    rdchk(aa, 8'h10);
    wr(aa, 8'h25);
    rdchk(aa, 8'h05);
    endt("unlock");
    wr(aa, 8'h95);
    rdchk(aa, 8'h95);
    run_len(1'b0, 4);
    rdchk(aa, 8'h15);
    rdchk(da, 8'h45);
    wr(aa, 8'h86);
    run_len(1'b0, 7);
    rdchk(da, 8'h46);
    endt("indirect read");
    wr(aa, 8'h10);
    wr(da, 8'h5c);
    run_len(1'b1, 6);
    rdchk(aa, 8'h11);
    wr(aa, 8'h90);
    run_len(1'b0, 6);
    rdchk(da, 8'h5c);
    endt("indirect write");
    wr(aa, 8'hd8);
    run_len(1'b0, 6);
    rdchk(da, 8'h48);
    run_len(1'b0, 6);
    rdchk(da, 8'h49);
    run_len(1'b0, 6);
    rdchk(aa, 8'h5b);
    endt("autoread");
    wr(ka, 8'h00);
    rdchk(ka, 8'h00);
    rdchk(aa, 8'h00);
    rdchk(ka, 8'h03);
    wr(ka, rtcial_pkg::key_first);
    wr(ka, rtcial_pkg::key_second);
    rdchk(ka, 8'h03);
    endt("relock and disable");
    summarize;
  end
  // the tests need well under 1000 cycles; this allows 5000 cycles, five times that
  initial begin
    #20000;
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize;
  end
endmodule
`default_nettype wire
